// *** emm_dev.sv ***
// Device end of the link plus the read-data FIFO that feeds it.
// Assumes the host makes the link clock; every pin is resynchronised to ref_clk.
`timescale 1ns/10ps

// ---------------------------------------------------------------------
// Read-data FIFO
// ---------------------------------------------------------------------
module emm_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   output logic [$clog2(D):0] level
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   // Full when pointers differ only in the wrap bit
   assign level = wr_ptr_r - rd_ptr_r;
   assign in_ready = (level != (AW+1)'(D));
   assign out_valid = (level != '0);
   assign out_data = mem[rd_ptr_r[AW-1:0]];

   // Storage
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      end
   end
endmodule : emm_fifo

// ---------------------------------------------------------------------
// Device end
// ---------------------------------------------------------------------
module emm_dev (
   input wire logic ref_clk,
   input wire logic sys_rst,
   emm_link_if.device link,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [7:0] wr_data,
   output emm_pkg::emm_mode_t mode
);
   typedef enum logic [2:0] {D_IDLE, D_BUSY, D_WAIT, D_DATA, D_END, D_REL} emm_dst_t;

   emm_dst_t st_r;
   emm_pkg::emm_mode_t mode_r;
   emm_pkg::emm_mode_t pend_r;
   logic clk_s1;
   logic clk_s2;
   logic clk_s3;
   logic cmd_s1;
   logic cmd_s2;
   logic rx_on_r;
   logic [4:0] rx_cnt_r;
   logic [14:0] rx_sh_r;
   logic [3:0] cnt_r;
   logic [7:0] dat_o_r;
   logic [7:0] oe_n_r;
   logic f_valid;
   logic [7:0] f_data;
   logic [4:0] f_level;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   // Two flops on every pin; the third clock flop only feeds edge detect
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         clk_s1 <= 1'b0;
         clk_s2 <= 1'b0;
         clk_s3 <= 1'b0;
         cmd_s1 <= 1'b1;
         cmd_s2 <= 1'b1;
      end else begin
         clk_s1 <= link.clk;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
         cmd_s1 <= link.cmd;
         cmd_s2 <= cmd_s1;
      end
   end

   // Edge events and the launch edge of the current mode
   wire rise = clk_s2 & ~clk_s3;
   wire fall = ~clk_s2 & clk_s3;
   wire launch = (mode_r == emm_pkg::EMM_BC) ? fall :
                 (mode_r == emm_pkg::EMM_DDR) ? (rise | fall) :
                 rise;

   // -----------------------------------------------------------------
   // Command receiver
   // -----------------------------------------------------------------
   // Command bits always on the rising edge, whatever the data rate
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rx_on_r <= 1'b0;
         rx_cnt_r <= '0;
         rx_sh_r <= '0;
      end else if (rise) begin
         if (!rx_on_r) begin
            rx_on_r <= ~cmd_s2;
            rx_cnt_r <= '0;
         end else begin
            rx_sh_r <= {rx_sh_r[13:0], cmd_s2};
            rx_cnt_r <= rx_cnt_r + 1'b1;
            if (rx_cnt_r == 5'(emm_pkg::CMD_BITS - 2)) rx_on_r <= 1'b0;
         end
      end
   end

   // Whole frame seen; a low end bit drops the frame
   wire cmd_done = rise & rx_on_r & (rx_cnt_r == 5'(emm_pkg::CMD_BITS - 2)) & cmd_s2;
   wire [5:0] rx_idx = rx_sh_r[13:8];
   wire [7:0] rx_arg = rx_sh_r[7:0];
   wire take_cmd = cmd_done & (st_r == D_IDLE);

   // -----------------------------------------------------------------
   // Read FIFO
   // -----------------------------------------------------------------
   // Pops only while a block is on the wire, so user writes back up here
   emm_fifo #(.W(emm_pkg::DAT_W), .D(emm_pkg::FIFO_DEPTH)) emm_fifo_inst (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data(wr_data),
      .out_valid(f_valid),
      .out_ready((st_r == D_DATA) & launch),
      .out_data(f_data),
      .level(f_level)
   );

   // A block starts only once it is whole, so it never stalls mid-way
   wire blk_ready = (f_level >= 5'(emm_pkg::BLK_LEN)) & f_valid;

   // -----------------------------------------------------------------
   // Transfer sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_r <= D_IDLE;
         mode_r <= emm_pkg::EMM_BC;
         pend_r <= emm_pkg::EMM_BC;
         cnt_r <= '0;
         dat_o_r <= emm_pkg::DAT_IDLE;
         oe_n_r <= 8'hff;
      end else begin
         unique case (st_r)
            D_IDLE: begin
               cnt_r <= '0;
               if (take_cmd && rx_idx == emm_pkg::CMD_SWITCH) begin
                  pend_r <= emm_pkg::emm_arg_mode(rx_arg);
                  dat_o_r <= 8'hfe;                               // Busy on line 0
                  oe_n_r <= 8'hfe;
                  st_r <= D_BUSY;
               end else if (take_cmd && rx_idx == emm_pkg::CMD_READ) begin
                  st_r <= D_WAIT;
               end
            end
            D_BUSY: begin
               // New timing applies only once busy is released
               if (rise) cnt_r <= cnt_r + 1'b1;
               if (rise && cnt_r == 4'(emm_pkg::BUSY_EDGES - 1)) begin
                  mode_r <= pend_r;
                  dat_o_r <= emm_pkg::DAT_IDLE;
                  oe_n_r <= 8'hff;
                  st_r <= D_IDLE;
               end
            end
            D_WAIT: begin
               if (launch && blk_ready) begin
                  dat_o_r <= emm_pkg::DAT_START;
                  oe_n_r <= 8'h00;
                  st_r <= D_DATA;
               end
            end
            D_DATA: begin
               if (launch) begin
                  dat_o_r <= f_data;
                  cnt_r <= cnt_r + 1'b1;
                  if (cnt_r == 4'(emm_pkg::BLK_LEN - 1)) st_r <= D_END;
               end
            end
            D_END: begin
               if (launch) begin
                  dat_o_r <= emm_pkg::DAT_IDLE;
                  st_r <= D_REL;
               end
            end
            D_REL: begin
               if (launch) begin
                  oe_n_r <= 8'hff;
                  st_r <= D_IDLE;
               end
            end
         endcase
      end
   end

   assign link.dat_o = dat_o_r;
   assign link.dat_oe_n = oe_n_r;
   assign mode = mode_r;
endmodule : emm_dev

// *** emm_pkg.sv ***
// Constants, types and helpers shared by both ends of the managed-flash bus link.
// Assumes both ends run on a 125 MHz ref_clk with a synchronous active-high reset.
//
// Summary of operation
// - Single-rate data captured on rising clock edge
// - Device starts in backward-compatible timing mode
// - Switch command with high-speed argument selects high-speed
// - Host keeps clock at most 26MHz before switch
// - Backward-compatible device launches outputs on falling edge; the code drives and releases busy on line 0 on rising edges
// - Dual rate moves data on both edges
// - Command line stays rising-edge only in dual rate
// - Identification mode clock at most 400 kHz
// - Clock limit 26 MHz legacy, 52 MHz high-speed
// - High-speed mode also works at 26MHz clock
package emm_pkg;

   // -----------------------------------------------------------------
   // Link framing
   // -----------------------------------------------------------------
   localparam int IDX_W = 6;
   localparam int ARG_W = 8;
   localparam int DAT_W = 8;
   localparam int CMD_BITS = 16;          // Start, index, argument, end
   localparam int BLK_LEN = 4;            // Bytes per read block
   localparam int FIFO_DEPTH = 16;
   localparam int BUSY_EDGES = 8;         // Busy length after a switch
   localparam logic [IDX_W-1:0] CMD_SWITCH = 6'h06;
   localparam logic [IDX_W-1:0] CMD_READ = 6'h11;
   localparam logic [ARG_W-1:0] ARG_HS = 8'h01;
   localparam logic [ARG_W-1:0] ARG_DDR = 8'h02;
   localparam logic [DAT_W-1:0] DAT_START = 8'h00;
   localparam logic [DAT_W-1:0] DAT_IDLE = 8'hff;

   // -----------------------------------------------------------------
   // Clock rates and divider counts
   // -----------------------------------------------------------------
   localparam int REF_KHZ = 125000;
   localparam int OD_MAX_KHZ = 400;
   localparam int BC_MAX_KHZ = 26000;
   localparam int HS_MAX_KHZ = 52000;
   // Half periods round up so the link clock never exceeds its limit
   localparam int OD_HALF = (REF_KHZ + 2 * OD_MAX_KHZ - 1) / (2 * OD_MAX_KHZ);
   localparam int BC_HALF = (REF_KHZ + 2 * BC_MAX_KHZ - 1) / (2 * BC_MAX_KHZ);
   localparam int HS_HALF = (REF_KHZ + 2 * HS_MAX_KHZ - 1) / (2 * HS_MAX_KHZ);

   // -----------------------------------------------------------------
   // Timing modes
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {EMM_BC, EMM_HS, EMM_DDR} emm_mode_t;

   // Mode requested by a switch argument; unknown values fall back
   function automatic emm_mode_t emm_arg_mode(input logic [ARG_W-1:0] arg);
      emm_arg_mode = (arg == ARG_DDR) ? EMM_DDR : (arg == ARG_HS) ? EMM_HS : EMM_BC;
   endfunction : emm_arg_mode

endpackage : emm_pkg

// *** emm_link_if.sv ***
// Link wires between host and device: clock, command and eight data lines.
// Assumes data lines are pulled high whenever the device releases them.
`timescale 1ns/10ps
interface emm_link_if;
   logic clk;
   logic cmd;
   logic [7:0] dat_o;
   logic [7:0] dat_oe_n;
   logic [7:0] dat;

   // Released lines read high through the pull-ups
   assign dat = dat_o | dat_oe_n;

   modport host (output clk, output cmd, input dat);
   modport device (input clk, input cmd, output dat_o, output dat_oe_n, input dat);
endinterface : emm_link_if

// *** emm_host.sv ***
// Host end of the link: makes the link clock, sends commands, collects read blocks.
// Assumes the device answers a switch with busy on data line 0 and a read with a block.
`timescale 1ns/10ps
module emm_host (
   input wire logic ref_clk,
   input wire logic sys_rst,
   emm_link_if.host link,
   input wire logic ident_mode,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [5:0] cmd_index,
   input wire logic [7:0] cmd_arg,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output emm_pkg::emm_mode_t mode
);
   typedef enum logic [2:0] {H_IDLE, H_SEND, H_BUSY_LO, H_BUSY_HI, H_READ, H_RECV} emm_hst_t;

   emm_hst_t st_r;
   emm_pkg::emm_mode_t mode_r;
   logic [7:0] div_r;
   logic clk_r;
   logic cmd_r;
   logic [15:0] tx_sh_r;
   logic [4:0] cnt_r;
   logic [5:0] idx_r;
   logic [7:0] arg_r;
   logic [7:0] dat_s1;
   logic [7:0] dat_s2;
   logic rd_valid_r;
   logic [7:0] rd_data_r;

   // -----------------------------------------------------------------
   // Link clock divider
   // -----------------------------------------------------------------
   // Slowest clock in identification, fast only after the device switched
   wire [7:0] half = ident_mode ? 8'(emm_pkg::OD_HALF) :
                     (mode_r == emm_pkg::EMM_BC) ? 8'(emm_pkg::BC_HALF) :
                     8'(emm_pkg::HS_HALF);
   wire tick = (div_r >= half - 8'h01);
   wire h_rise = tick & ~clk_r;
   wire h_fall = tick & clk_r;
   // Data sampled on rising edges, both edges in dual rate
   wire sample = h_rise | (h_fall & (mode_r == emm_pkg::EMM_DDR));

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         div_r <= '0;
         clk_r <= 1'b0;
      end else begin
         div_r <= tick ? 8'h00 : div_r + 8'h01;
         if (tick) clk_r <= ~clk_r;
      end
   end

   // Data pins come from another domain
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         dat_s1 <= 8'hff;
         dat_s2 <= 8'hff;
      end else begin
         dat_s1 <= link.dat;
         dat_s2 <= dat_s1;
      end
   end

   // -----------------------------------------------------------------
   // Command and read sequencer
   // -----------------------------------------------------------------
   assign cmd_ready = (st_r == H_IDLE);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_r <= H_IDLE;
         mode_r <= emm_pkg::EMM_BC;
         cmd_r <= 1'b1;
         tx_sh_r <= '1;
         cnt_r <= '0;
         idx_r <= '0;
         arg_r <= '0;
         rd_valid_r <= 1'b0;
         rd_data_r <= '0;
      end else begin
         rd_valid_r <= 1'b0;
         unique case (st_r)
            H_IDLE: begin
               cnt_r <= '0;
               if (cmd_valid) begin
                  tx_sh_r <= {1'b0, cmd_index, cmd_arg, 1'b1};
                  idx_r <= cmd_index;
                  arg_r <= cmd_arg;
                  st_r <= H_SEND;
               end
            end
            H_SEND: begin
               // Launch on falling edge so the device samples mid-bit
               if (h_fall) begin
                  if (cnt_r == 5'(emm_pkg::CMD_BITS)) begin
                     cmd_r <= 1'b1;
                     cnt_r <= '0;
                     st_r <= (idx_r == emm_pkg::CMD_SWITCH) ? H_BUSY_LO :
                             (idx_r == emm_pkg::CMD_READ) ? H_READ : H_IDLE;
                  end else begin
                     cmd_r <= tx_sh_r[15];
                     tx_sh_r <= {tx_sh_r[14:0], 1'b1};
                     cnt_r <= cnt_r + 1'b1;
                  end
               end
            end
            H_BUSY_LO: begin
               if (sample && !dat_s2[0]) st_r <= H_BUSY_HI;
            end
            H_BUSY_HI: begin
               // Speed up only after busy has ended
               if (sample && dat_s2[0]) begin
                  mode_r <= emm_pkg::emm_arg_mode(arg_r);
                  st_r <= H_IDLE;
               end
            end
            H_READ: begin
               if (sample && dat_s2 == emm_pkg::DAT_START) st_r <= H_RECV;
            end
            H_RECV: begin
               if (sample) begin
                  rd_data_r <= dat_s2;
                  rd_valid_r <= 1'b1;
                  cnt_r <= cnt_r + 1'b1;
                  if (cnt_r == 5'(emm_pkg::BLK_LEN - 1)) st_r <= H_IDLE;
               end
            end
         endcase
      end
   end

   assign link.clk = clk_r;
   assign link.cmd = cmd_r;
   assign rd_valid = rd_valid_r;
   assign rd_data = rd_data_r;
   assign mode = mode_r;
endmodule : emm_host

// *** emm_link_chk.sv ***
// Checker for the wires between host and device ends of the link.
// Assumes it is instantiated beside the link interface, fed on ref_clk.
`timescale 1ns/10ps
module emm_link_chk (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk,
   input wire logic cmd,
   input wire logic [7:0] dat_o,
   input wire logic [7:0] dat_oe_n,
   input wire logic [7:0] dat
);
   localparam int HALF_MAX = emm_pkg::OD_HALF;
   logic clk_d_r;
   logic [3:0] busy_cnt_r;
   wire link_rise = clk & ~clk_d_r;
   wire busy_drv = (dat_oe_n == 8'hfe);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   // -----------------------------------------------------------------
   // Busy length counter
   // -----------------------------------------------------------------
   // Counts link rises while only line 0 is driven low
   always_ff @(posedge ref_clk) begin
      clk_d_r <= clk;
      busy_cnt_r <= (sys_rst || !busy_drv) ? 4'h0 : busy_cnt_r + {3'h0, link_rise};
   end

   sequence s_rise;
      !clk ##1 clk;
   endsequence
   sequence s_fall;
      clk ##1 !clk;
   endsequence

   // -----------------------------------------------------------------
   // Wire checks
   // -----------------------------------------------------------------
   a_reset_idle_state: assert property ($fell(sys_rst) |-> !clk && cmd && dat_oe_n == 8'hff)
      else $error("link not idle after reset");
   a_cmd_moves_low: assert property (!$stable(cmd) |-> !clk)
      else $error("command line changed while clock high");
   a_cmd_hold_rise: assert property (s_rise |=> $stable(cmd))
      else $error("command line moved just after rising edge");
   a_clk_high_min: assert property (s_rise |=> clk)
      else $error("link clock high for one cycle only");
   a_clk_low_min: assert property (s_fall |=> !clk)
      else $error("link clock low for one cycle only");
   a_clk_high_max: assert property (s_rise |-> ##[1:HALF_MAX] !clk)
      else $error("link clock high too long");
   a_busy_length: assert property ($past(busy_drv) && !busy_drv |-> busy_cnt_r == 4'h8)
      else $error("busy length wrong");
   a_data_drive_legal: assert property (dat_oe_n inside {8'hff, 8'hfe, 8'h00})
      else $error("data lines driven partly");
   a_busy_line_low: assert property (busy_drv |-> !dat_o[0] && !dat[0])
      else $error("busy not shown low on line 0");
endmodule : emm_link_chk

// *** emmc_bus_timing_mode_control_bench.sv ***
// Bench joining host and device ends over one link interface.
// Assumes a 125 MHz ref_clk; the host makes the link clock itself.
`timescale 1ns/10ps
module emmc_bus_timing_mode_control_bench;
   logic ref_clk, sys_rst, ident_mode, cmd_valid, wr_valid;
   logic [5:0] cmd_index;
   logic [7:0] cmd_arg, wr_data, rd_data;
   wire cmd_ready, rd_valid, wr_ready;
   emm_pkg::emm_mode_t host_mode, dev_mode;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [7:0] rd_q[$];

   emm_link_if link();
   emm_host emm_host_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
      .ident_mode(ident_mode), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_index(cmd_index), .cmd_arg(cmd_arg), .rd_valid(rd_valid), .rd_data(rd_data),
      .mode(host_mode));
   emm_dev emm_dev_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .mode(dev_mode));
   emm_link_chk emm_link_chk_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk(link.clk),
      .cmd(link.cmd), .dat_o(link.dat_o), .dat_oe_n(link.dat_oe_n), .dat(link.dat));

   // -----------------------------------------------------------------
   // Clock, capture and hang guard
   // -----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Read pulses last one cycle, so gather them as they pass
   always @(posedge ref_clk) begin
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         results();
      end
   end

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results

   // Sends one frame, times one link period, then waits for the end
   task automatic send_cmd(input logic [5:0] idx, input logic [7:0] arg, input int per);
      int n;
      cmd_index <= idx;
      cmd_arg <= arg;
      cmd_valid <= 1'b1;
      do @(posedge ref_clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      n = 0;
      // Start from a fresh rise so a part-gone high phase is not counted
      while (link.clk !== 1'b0) @(posedge ref_clk);
      while (link.clk !== 1'b1) @(posedge ref_clk);
      do begin @(posedge ref_clk); n++; end while (link.clk !== 1'b0);
      do begin @(posedge ref_clk); n++; end while (link.clk !== 1'b1);
      check("link period", n[15:0], per[15:0]);
      n = 0;
      while (cmd_ready !== 1'b1 && n < 30000) begin @(posedge ref_clk); n++; end
      check("cmd done", {15'h0, cmd_ready}, 16'h1);
   endtask : send_cmd

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      check("host mode", {14'h0, host_mode}, {14'h0, emm_pkg::EMM_BC});
      check("dev mode", {14'h0, dev_mode}, {14'h0, emm_pkg::EMM_BC});
      check("idle wires", {6'h0, link.clk, link.cmd, link.dat}, 16'h01ff);
      $display("test reset done");
   endtask : t_reset

   // Fills the buffer to the brim, then offers one byte that must be refused
   task automatic t_fill();
      wr_valid <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         wr_data <= i[7:0];
         do @(posedge ref_clk); while (wr_ready !== 1'b1);
      end
      wr_data <= 8'hee;
      repeat (3) @(posedge ref_clk);
      check("full", {15'h0, wr_ready}, 16'h0);
      wr_valid <= 1'b0;
      $display("test fill done");
   endtask : t_fill

   task automatic t_read(input logic [7:0] first, input int per);
      rd_q.delete();
      send_cmd(emm_pkg::CMD_READ, 8'h00, per);
      // Let the last pulse land in the queue and the device finish its release
      repeat (2 * per) @(posedge ref_clk);
      check("block len", 16'(rd_q.size()), 16'(emm_pkg::BLK_LEN));
      for (int i = 0; i < 4; i++) check("rd byte", {8'h0, rd_q[i]}, {8'h0, first + i[7:0]});
      check("released", {8'h0, link.dat}, {8'h0, emm_pkg::DAT_IDLE});
      check("drive off", {8'h0, link.dat_oe_n}, 16'h00ff);
      $display("test read done");
   endtask : t_read

   task automatic t_switch(input logic [7:0] arg, input int per, input emm_pkg::emm_mode_t m);
      send_cmd(emm_pkg::CMD_SWITCH, arg, per);
      check("host mode", {14'h0, host_mode}, {14'h0, m});
      check("dev mode", {14'h0, dev_mode}, {14'h0, m});
      $display("test switch done");
   endtask : t_switch

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      ident_mode = 1'b0;
      cmd_valid = 1'b0;
      cmd_index = 6'h00;
      cmd_arg = 8'h00;
      wr_valid = 1'b0;
      wr_data = 8'h00;
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      t_reset();
      t_fill();
      t_read(8'h00, 2 * emm_pkg::BC_HALF);
      check("space", {15'h0, wr_ready}, 16'h1);
      t_switch(emm_pkg::ARG_HS, 2 * emm_pkg::BC_HALF, emm_pkg::EMM_HS);
      t_read(8'h04, 2 * emm_pkg::HS_HALF);
      t_switch(emm_pkg::ARG_DDR, 2 * emm_pkg::HS_HALF, emm_pkg::EMM_DDR);
      t_read(8'h08, 2 * emm_pkg::HS_HALF);
      // Slow identification clock costs thousands of cycles, so only one frame
      ident_mode <= 1'b1;
      t_switch(8'h00, 2 * emm_pkg::OD_HALF, emm_pkg::EMM_BC);
      ident_mode <= 1'b0;
      t_read(8'h0c, 2 * emm_pkg::BC_HALF);
      results();
   end
endmodule : emmc_bus_timing_mode_control_bench
